// *** pkg/ub0_pkg.sv ***
// Purpose: constants for the bank 0 serial port register front end
// Assumes: classic Wishbone, 32-bit data, register index times four is the byte address
// Notes:   event codes are the legacy four-bit identification values
//
// How it works
// [RULE1] nine byte registers decoded at indices 00h to 08h
// [RULE2] reset leaves legacy mode with legacy enable bit meanings
// [RULE3] data port read returns holding byte or oldest receive fifo entry
// [RULE4] data port write loads holding byte or pushes onto transmit fifo
// [RULE5] enable bit 5 writable in extended mode only, bits 4 to 7 else cleared
// [RULE6] legacy enable bit 0 gates receive level and time-out, codes 0100/1100
// [RULE7] legacy enable bit 1 gates transmit low level, code 0010
// [RULE8] enable bit 2 gates line status events, code 0110
// [RULE9] enable bit 3 gates modem status events, code 0000
// [RULE10] extended enable bit 0: receive level at threshold or time-out
// [RULE11] extended enable bit 1: transmit level below threshold or holding empty
// [RULE12] extended enable bit 5: transmit shifter and fifo both empty
// [RULE13] index 02h reads event identification, writes fifo control
// [RULE14] legacy mode reports only the highest of four priority levels
// [RULE15] legacy identification bit 0 is low while anything pending, resets high
// [RULE16] legacy identification layout matches the classic fifo serial controller
// [RULE17] priority: line status, receive, transmit low, modem; 0001 is none
// [RULE18] transmit low interrupt clears on an identification read that returns 0010, or on a data write
// [RULE19] extended event flags show pending events regardless of enables
// [RULE20] interrupt output high while any pending event is enabled
// [RULE21] reserved enable bits read zero and ignore writes
package ub0_pkg;
	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_DATA = 4'h0;
	localparam logic [3:0] IDX_INTEN = 4'h1;
	localparam logic [3:0] IDX_EID  = 4'h2;
	localparam logic [3:0] IDX_LCTL = 4'h3;
	localparam logic [3:0] IDX_MCTL = 4'h4;
	localparam logic [3:0] IDX_LSTAT = 4'h5;
	localparam logic [3:0] IDX_MSTAT = 4'h6;
	localparam logic [3:0] IDX_SPAD = 4'h7;
	localparam logic [3:0] IDX_EXC1 = 4'h8;
	// ----------------------------------------------------------------
	// field positions, masks, reset values
	// ----------------------------------------------------------------
	localparam int FCTL_EN = 0;
	localparam int FCTL_RXSR = 1;
	localparam int FCTL_TXSR = 2;
	localparam int FCTL_TXTH = 4;
	localparam int FCTL_RXTH = 6;
	localparam int IE_RX = 0;
	localparam int IE_TX = 1;
	localparam int IE_LS = 2;
	localparam int IE_MS = 3;
	localparam int IE_TXEMP = 5;
	localparam int EXC_SEL = 0;
	localparam logic [7:0] INTEN_LEGACY_MASK = 8'h0f;
	localparam logic [7:0] INTEN_EXT_MASK = 8'h2f;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// ----------------------------------------------------------------
	// event codes and fifo geometry
	// ----------------------------------------------------------------
	localparam logic [3:0] EID_LS = 4'h6;
	localparam logic [3:0] EID_RX = 4'h4;
	localparam logic [3:0] EID_TO = 4'hc;
	localparam logic [3:0] EID_TX = 4'h2;
	localparam logic [3:0] EID_MS = 4'h0;
	localparam logic [3:0] EID_NONE = 4'h1;
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] CAP_FIFO = 5'h10;
	localparam logic [4:0] CAP_HOLD = 5'h01;
	typedef logic [4:0] ub0_cnt_t;

	function automatic ub0_cnt_t ub0_tx_thr(input logic [1:0] sel);
		case (sel)
			2'h0: ub0_tx_thr = 5'h01;
			2'h1: ub0_tx_thr = 5'h03;
			2'h2: ub0_tx_thr = 5'h09;
			default: ub0_tx_thr = 5'h0d;
		endcase
	endfunction : ub0_tx_thr

	function automatic ub0_cnt_t ub0_rx_thr(input logic [1:0] sel);
		case (sel)
			2'h0: ub0_rx_thr = 5'h01;
			2'h1: ub0_rx_thr = 5'h04;
			2'h2: ub0_rx_thr = 5'h08;
			default: ub0_rx_thr = 5'h0e;
		endcase
	endfunction : ub0_rx_thr
endpackage : ub0_pkg

// *** logic/ub0_fifo.sv ***
// Purpose: byte fifo whose usable depth is set at run time
// Assumes: push is never made while full, pop never while empty
// Notes:   a cap of one turns it into a plain holding register
`timescale 1ns/1ns
module ub0_fifo
	import ub0_pkg::*;
(
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic           clr_i,
	input  wire ub0_pkg::ub0_cnt_t cap_i,
	input  wire logic           push_i,
	input  wire logic [7:0]     wdata_i,
	input  wire logic           pop_i,
	output logic [7:0]          rdata_o,
	output ub0_pkg::ub0_cnt_t   count_o,
	output logic                full_o
);
	import ub0_pkg::*;
	typedef struct packed {
		logic [FIFO_DEPTH-1:0][7:0] mem;
		logic [3:0]                 wp;
		logic [3:0]                 rp;
		ub0_cnt_t                   cnt;
	} ub0_fifo_s;
	ub0_fifo_s st_reg;
	ub0_fifo_s st_next;

	assign rdata_o = st_reg.mem[st_reg.rp];
	assign count_o = st_reg.cnt;
	assign full_o  = (st_reg.cnt >= cap_i);

	always_comb begin
		st_next = st_reg;
		if (clr_i) begin
			st_next.wp = '0;
			st_next.rp = '0;
			st_next.cnt = '0;
		end else begin
			if (push_i) begin
				st_next.mem[st_reg.wp] = wdata_i;
				st_next.wp = st_reg.wp + 4'h1;
			end
			if (pop_i)
				st_next.rp = st_reg.rp + 4'h1;
			st_next.cnt = st_reg.cnt + ub0_cnt_t'(push_i) - ub0_cnt_t'(pop_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
endmodule : ub0_fifo

// *** logic/ub0_eid_enc.sv ***
// Purpose: legacy priority encoder for the event identification code
// Assumes: each input is already pending and enabled
// Notes:   purely combinational
`timescale 1ns/1ns
module ub0_eid_enc
	import ub0_pkg::*;
(
	input  wire logic       ls_i,
	input  wire logic       rx_i,
	input  wire logic       to_i,
	input  wire logic       tx_i,
	input  wire logic       ms_i,
	output logic [3:0]      code_o,
	output logic            pend_o
);
	import ub0_pkg::*;
	always_comb begin
		pend_o = ls_i | rx_i | to_i | tx_i | ms_i;
		if (ls_i)                               // RULE17
			code_o = EID_LS;
		else if (rx_i)
			code_o = EID_RX;
		else if (to_i)
			code_o = EID_TO;
		else if (tx_i)
			code_o = EID_TX;
		else if (ms_i)
			code_o = EID_MS;
		else
			code_o = EID_NONE;
	end
endmodule : ub0_eid_enc

// *** logic/ub0_bank0.sv ***
// Purpose: bank 0 register front end of the serial port, Wishbone slave
// Assumes: receiver, transmitter and status logic sit behind the side ports
// Notes:   every access is answered one cycle after it is presented
`timescale 1ns/1ns
module ub0_bank0
	import ub0_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [5:0]  adr_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic             ack_o,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	output logic             rx_ready_o,
	input  wire logic        rx_timeout_i,
	output logic             tx_valid_o,
	output logic [7:0]       tx_data_o,
	input  wire logic        tx_ready_i,
	input  wire logic        tx_shift_empty_i,
	input  wire logic [7:0]  line_status_i,
	input  wire logic        line_status_event_i,
	input  wire logic [7:0]  modem_status_i,
	input  wire logic        modem_status_event_i,
	output logic             line_status_read_o,
	output logic             modem_status_read_o,
	output logic             rx_reset_o,
	output logic             tx_reset_o,
	output logic [7:0]       line_control_o,
	output logic [7:0]       modem_control_o,
	output logic             fifo_enable_o,
	output logic             extended_o,
	output logic             irq_o
);
	import ub0_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} ub0_bus_e;
	typedef struct packed {
		ub0_bus_e   bus;
		logic [31:0] dat;
		logic [7:0] inten;
		logic       fen;
		logic [1:0] txth;
		logic [1:0] rxth;
		logic [7:0] lctl;
		logic [7:0] mctl;
		logic [7:0] spad;
		logic       ext;
		logic       tx_low_prev;
		logic       tx_int;
		logic       lstat_rd;
		logic       mstat_rd;
		logic       rx_rst;
		logic       tx_rst;
	} ub0_state_s;
	ub0_state_s st_reg;
	ub0_state_s st_next;

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	logic [3:0] idx;
	logic       take;
	logic       wr;
	logic       rd;
	assign idx  = adr_i[5:2];
	// side effects happen once, on the cycle the access is taken
	assign take = cyc_i && stb_i && (st_reg.bus == BUS_IDLE);
	assign wr   = take && we_i && sel_i[0];
	assign rd   = take && !we_i;

	// ----------------------------------------------------------------
	// fifos
	// ----------------------------------------------------------------
	ub0_cnt_t   cap;
	ub0_cnt_t   rx_cnt;
	ub0_cnt_t   tx_cnt;
	logic [7:0] rx_byte;
	logic       rx_full;
	logic       tx_full;
	logic       rx_pop;
	logic       tx_push;
	logic       fen_chg;
	logic       rx_clr;
	logic       tx_clr;

	assign cap     = st_reg.fen ? CAP_FIFO : CAP_HOLD;
	assign rx_ready_o = !rx_full && !rx_clr;
	assign rx_pop  = rd && (idx == IDX_DATA) && (rx_cnt != '0);                // RULE3
	assign tx_push = wr && (idx == IDX_DATA) && !tx_full;                      // RULE4
	assign tx_valid_o = (tx_cnt != '0);
	// turning the fifos on or off empties both
	assign fen_chg = wr && (idx == IDX_EID) && (dat_i[FCTL_EN] != st_reg.fen);
	assign rx_clr  = fen_chg || (wr && (idx == IDX_EID) && dat_i[FCTL_RXSR]);
	assign tx_clr  = fen_chg || (wr && (idx == IDX_EID) && dat_i[FCTL_TXSR]);

	ub0_fifo u_rx_fifo (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clr_i   (rx_clr),
		.cap_i   (cap),
		.push_i  (rx_valid_i && rx_ready_o),
		.wdata_i (rx_data_i),
		.pop_i   (rx_pop),
		.rdata_o (rx_byte),
		.count_o (rx_cnt),
		.full_o  (rx_full)
	);

	ub0_fifo u_tx_fifo (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clr_i   (tx_clr),
		.cap_i   (cap),
		.push_i  (tx_push),
		.wdata_i (dat_i[7:0]),
		.pop_i   (tx_valid_o && tx_ready_i && !tx_clr),
		.rdata_o (tx_data_o),
		.count_o (tx_cnt),
		.full_o  (tx_full)
	);

	// ----------------------------------------------------------------
	// events
	// ----------------------------------------------------------------
	logic       ev_rx;
	logic       ev_to;
	logic       ev_tx;
	logic       ev_txemp;
	logic       tx_low;
	logic [7:0] ext_ev;
	logic [3:0] code;
	logic       leg_pend;
	logic [7:0] eid_rd;

	assign ev_rx  = st_reg.fen ? (rx_cnt >= ub0_rx_thr(st_reg.rxth)) : (rx_cnt != '0);
	assign ev_to  = st_reg.fen && rx_timeout_i && (rx_cnt != '0);
	// the threshold only matters in extended mode; legacy waits for empty
	assign tx_low = (st_reg.fen && st_reg.ext) ? (tx_cnt < ub0_tx_thr(st_reg.txth))
	                                           : (tx_cnt == '0);
	assign ev_tx  = st_reg.ext ? tx_low : st_reg.tx_int;
	assign ev_txemp = tx_shift_empty_i && (tx_cnt == '0);
	// flags show the event even with its enable off
	assign ext_ev = {2'b00, ev_txemp, 1'b0, modem_status_event_i,             // RULE19
	                 line_status_event_i, ev_tx, ev_rx || ev_to};

	ub0_eid_enc u_enc (
		.ls_i   (st_reg.inten[IE_LS] && line_status_event_i),                     // RULE8
		.rx_i   (st_reg.inten[IE_RX] && ev_rx),                                   // RULE6
		.to_i   (st_reg.inten[IE_RX] && ev_to),                                   // RULE6
		.tx_i   (st_reg.inten[IE_TX] && st_reg.tx_int),                           // RULE7
		.ms_i   (st_reg.inten[IE_MS] && modem_status_event_i),                    // RULE9
		.code_o (code),
		.pend_o (leg_pend)
	);

	// legacy layout: fifo enable twice on top, code below, bit 0 low when pending
	assign eid_rd = st_reg.ext ? ext_ev                                       // RULE16
	                           : {st_reg.fen, st_reg.fen, 2'b00, code};       // RULE14 RULE15

	// extended mode: 0 gates rx level/time-out, 1 tx level, 5 tx empty
	assign irq_o = st_reg.ext ? |(ext_ev & st_reg.inten) : leg_pend;  // RULE10 RULE11 RULE12 RULE20

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	function automatic logic [7:0] ub0_rd_mux(input logic [3:0] i, input ub0_state_s s,
	                                          input logic [7:0] rxd, input logic [7:0] eid,
	                                          input logic [7:0] ls, input logic [7:0] ms);
		case (i)
			IDX_DATA: ub0_rd_mux = rxd;
			IDX_INTEN: ub0_rd_mux = s.inten;
			IDX_EID:   ub0_rd_mux = eid;
			IDX_LCTL:  ub0_rd_mux = s.lctl;
			IDX_MCTL:  ub0_rd_mux = s.mctl;
			IDX_LSTAT: ub0_rd_mux = ls;
			IDX_MSTAT: ub0_rd_mux = ms;
			IDX_SPAD:  ub0_rd_mux = s.spad;
			IDX_EXC1: ub0_rd_mux = {7'h00, s.ext};
			default:  ub0_rd_mux = BYTE_RST;
		endcase
	endfunction : ub0_rd_mux

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.lstat_rd = 1'b0;
		st_next.mstat_rd = 1'b0;
		st_next.rx_rst = 1'b0;
		st_next.tx_rst = 1'b0;
		st_next.tx_low_prev = tx_low;
		case (st_reg.bus)
			BUS_IDLE: begin
				if (take) begin                                                     // RULE1
					st_next.bus = BUS_ACK;
					st_next.dat = {24'h000000,
					               ub0_rd_mux(idx, st_reg, rx_byte, eid_rd,
					                          line_status_i, modem_status_i)};
				end
			end
			BUS_ACK:
				st_next.bus = BUS_IDLE;
			default:
				st_next.bus = BUS_IDLE;
		endcase
		if (rd && idx == IDX_LSTAT)
			st_next.lstat_rd = 1'b1;
		if (rd && idx == IDX_MSTAT)
			st_next.mstat_rd = 1'b1;
		if (wr) begin
			case (idx)
				IDX_INTEN:
					st_next.inten = dat_i[7:0] & (st_reg.ext ? INTEN_EXT_MASK   // RULE5 RULE21
					                                         : INTEN_LEGACY_MASK);
				IDX_EID: begin                                                      // RULE13
					st_next.fen  = dat_i[FCTL_EN];
					st_next.txth = dat_i[FCTL_TXTH +: 2];
					st_next.rxth = dat_i[FCTL_RXTH +: 2];
					st_next.rx_rst = dat_i[FCTL_RXSR];
					st_next.tx_rst = dat_i[FCTL_TXSR];
				end
				IDX_LCTL: st_next.lctl = dat_i[7:0];
				IDX_MCTL: st_next.mctl = dat_i[7:0];
				IDX_SPAD: st_next.spad = dat_i[7:0];
				IDX_EXC1: st_next.ext = dat_i[EXC_SEL];
				default: ;
			endcase
		end
		if (!st_next.ext)
			st_next.inten = st_next.inten & INTEN_LEGACY_MASK;                  // RULE5
		// clear first, so a new empty edge in the same cycle wins
		if ((rd && idx == IDX_EID && code == EID_TX) || (wr && idx == IDX_DATA))
			st_next.tx_int = 1'b0;                                              // RULE18
		if (tx_low && !st_reg.tx_low_prev)
			st_next.tx_int = 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;                                                       // RULE2
			st_reg.bus <= BUS_IDLE;
			st_reg.lctl <= BYTE_RST;
			st_reg.tx_low_prev <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ack_o = (st_reg.bus == BUS_ACK);
	assign dat_o = st_reg.dat;
	assign line_status_read_o  = st_reg.lstat_rd;
	assign modem_status_read_o = st_reg.mstat_rd;
	assign rx_reset_o      = st_reg.rx_rst;
	assign tx_reset_o      = st_reg.tx_rst;
	assign line_control_o  = st_reg.lctl;
	assign modem_control_o = st_reg.mctl;
	assign fifo_enable_o   = st_reg.fen;
	assign extended_o      = st_reg.ext;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ack_single: assert property (ack_o |=> !ack_o)                     // RULE1
		else $error("ack held longer than one cycle");

	chk_ack_after_take: assert property (take |=> ack_o)                   // RULE1
		else $error("taken access not answered in the next cycle");

	chk_lstat_pulse: assert property (rd && idx == IDX_LSTAT               // RULE1
		|=> line_status_read_o && ack_o)
		else $error("line status read pulse missing");

	chk_mstat_pulse: assert property (rd && idx == IDX_MSTAT               // RULE1
		|=> modem_status_read_o && ack_o)
		else $error("modem status read pulse missing");

	chk_reset_legacy: assert property (@(posedge clk_i) disable iff (1'b0)  // RULE2
		rst_i |=> (!extended_o && st_reg.inten == '0 && !fifo_enable_o))
		else $error("reset did not leave legacy mode");

	chk_enable_upper_clear: assert property (!st_reg.ext |-> st_reg.inten[7:4] == 4'h0) // RULE5
		else $error("upper enable bits set in legacy mode");

	chk_enable_reserved: assert property (wr && idx == IDX_INTEN && st_reg.ext // RULE21
		|=> st_reg.inten[4] == 1'b0 && st_reg.inten[7:6] == 2'b00)
		else $error("reserved enable bit took a write");

	chk_pending_idle: assert property (rd && idx == IDX_EID && !st_reg.ext && !irq_o // RULE15
		|=> ack_o && dat_o[3:0] == EID_NONE)
		else $error("idle identification read not 0001");

	chk_pending_bit: assert property (!st_reg.ext |-> eid_rd[0] == !leg_pend) // RULE15
		else $error("pending flag disagrees with the sources");

	chk_ls_first: assert property (!st_reg.ext && st_reg.inten[IE_LS] && line_status_event_i // RULE17
		|-> code == EID_LS && irq_o)
		else $error("line status not top priority");

	chk_rx_second: assert property (!st_reg.ext && !st_reg.inten[IE_LS]    // RULE17
		&& st_reg.inten[IE_RX] && ev_rx |-> code == EID_RX)
		else $error("receive level not reported below line status");

	chk_tx_gate: assert property (!st_reg.ext && !st_reg.inten[IE_TX]      // RULE7
		|-> code != EID_TX)
		else $error("transmit low reported while disabled");

	chk_ms_gate: assert property (!st_reg.ext && !st_reg.inten[IE_MS]      // RULE9
		|-> code != EID_MS)
		else $error("modem status reported while disabled");

	chk_fifo_clear: assert property (fen_chg |=> rx_cnt == '0 && tx_cnt == '0) // RULE13
		else $error("fifo enable change did not empty the fifos");

	chk_txd_push: assert property (tx_push && !tx_clr && !(tx_valid_o && tx_ready_i) // RULE4
		|=> tx_cnt == $past(tx_cnt) + 5'h01)
		else $error("data write did not reach transmit side");

	chk_data_push: assert property (tx_push |=> tx_valid_o)                // RULE4
		else $error("data write left the transmit side empty");

	chk_rxd_pop: assert property (rx_pop && !rx_clr && !(rx_valid_i && rx_ready_o) // RULE3
		|=> rx_cnt == $past(rx_cnt) - 5'h01)
		else $error("data read did not drain receive side");

	chk_tx_int_clear: assert property (wr && idx == IDX_DATA && !(tx_low && !st_reg.tx_low_prev) // RULE18
		|=> !st_reg.tx_int)
		else $error("transmit low interrupt survived data write");

	chk_txemp_irq: assert property (st_reg.ext && st_reg.inten[IE_TXEMP]   // RULE12
		&& ev_txemp |-> irq_o)
		else $error("transmitter empty did not raise the interrupt");

	chk_legacy_quiet: assert property (!st_reg.ext && st_reg.inten == '0 |-> !irq_o) // RULE20
		else $error("legacy interrupt with nothing enabled");

	chk_ext_enable: assert property (st_reg.ext && st_reg.inten == '0 |-> !irq_o) // RULE20
		else $error("interrupt with nothing enabled");
endmodule : ub0_bank0

// *** testbench/ub0_serial_end.sv ***
// Purpose: receiver and transmitter stand-in behind the register front end
// Assumes: one clock; the bench asks for each received byte with a one-cycle send pulse
// Notes:   the shifter stays busy a few cycles after each pop
`timescale 1ns/1ns
module ub0_serial_end (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       send_i,
	input  wire logic [7:0] byte_i,
	input  wire logic       stall_i,
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	input  wire logic       rx_ready_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	output logic            tx_shift_empty_o,
	output logic [7:0]      last_tx_o,
	output logic [7:0]      tx_count_o
);
	logic [7:0] held_reg;
	logic [2:0] busy_reg;
	// idle data shows the inverse of the last byte so a stale value cannot pass
	assign rx_data_o        = rx_valid_o ? held_reg : ~held_reg;
	assign tx_ready_o       = !stall_i && busy_reg == 3'h0;
	assign tx_shift_empty_o = busy_reg == 3'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_valid_o <= 1'b0;
			held_reg   <= 8'h00;
			busy_reg   <= 3'h0;
			last_tx_o  <= 8'h00;
			tx_count_o <= 8'h00;
		end else begin
			if (send_i) begin
				rx_valid_o <= 1'b1;
				held_reg   <= byte_i;
			end else if (rx_valid_o && rx_ready_i) begin
				rx_valid_o <= 1'b0;
			end
			if (tx_valid_i && tx_ready_o) begin
				busy_reg   <= 3'h4;
				last_tx_o  <= tx_data_i;
				tx_count_o <= tx_count_o + 8'h01;
			end else if (busy_reg != 3'h0) begin
				busy_reg <= busy_reg - 3'h1;
			end
		end
	end
endmodule : ub0_serial_end

// *** testbench/ub0_bank0_bench.sv ***
// Purpose: self-checking bench for the bank 0 register front end
// Assumes: classic Wishbone master, fifos off and legacy mode after reset
// Notes:   register rows first, then interrupt, fifo and extended cases
`timescale 1ns/1ns
module ub0_bank0_bench;
	import ub0_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, send, stall, rxv, rxr, rxt, txv, txr, txe;
	logic lse, mse, irq, fen, ext, lsrd, msrd, rxrs, txrs;
	logic [5:0]  adr;
	logic [31:0] dw, dr, q;
	logic [7:0]  rxd, txd, sbyte, last_tx, txn, lcto, mcto;
	int fail_count, checks;
	typedef struct { logic [5:0] a; logic [7:0] w; logic [7:0] e; } ub0_row_s;
	ub0_row_s rows [9] = '{'{6'h0c, 8'ha5, 8'ha5}, '{6'h10, 8'h3c, 8'h3c},
		'{6'h1c, 8'h5a, 8'h5a}, '{6'h04, 8'hff, 8'h0f}, '{6'h24, 8'hff, 8'h00},
		'{6'h3c, 8'hff, 8'h00}, '{6'h14, 8'hff, 8'h61}, '{6'h18, 8'hff, 8'h90},
		'{6'h04, 8'h00, 8'h00}};

	ub0_bank0 uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dw), .dat_o(dr),
		.we_i(we), .sel_i(4'hf), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .rx_valid_i(rxv),
		.rx_data_i(rxd), .rx_ready_o(rxr), .rx_timeout_i(rxt), .tx_valid_o(txv),
		.tx_data_o(txd), .tx_ready_i(txr), .tx_shift_empty_i(txe), .line_status_i(8'h61),
		.line_status_event_i(lse), .modem_status_i(8'h90), .modem_status_event_i(mse),
		.line_status_read_o(lsrd), .modem_status_read_o(msrd), .rx_reset_o(rxrs),
		.tx_reset_o(txrs), .line_control_o(lcto), .modem_control_o(mcto),
		.fifo_enable_o(fen), .extended_o(ext),
		.irq_o(irq));
	ub0_serial_end far (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .byte_i(sbyte),
		.stall_i(stall), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_ready_i(rxr),
		.tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr), .tx_shift_empty_o(txe),
		.last_tx_o(last_tx), .tx_count_o(txn));

	// ----------------------------------------------------------------
	// clock, reset, watchdog
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#300000;
		fail_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_of_test();
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk

	// one classic cycle; the request holds until ack is sampled high or 50 cycles pass
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dw  <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (n >= 50)
			chk(1'b0, 1'b1, "no ack");
	endtask : wb

	task automatic rd(input logic [5:0] a, input logic [7:0] e, input string m);
		wb(1'b0, a, 8'h00);
		chk(q, {24'h0, e}, m);
	endtask : rd

	task automatic rx_send(input logic [7:0] b);
		int n;
		n = 0;
		@(posedge clk_i);
		send  <= 1'b1;
		sbyte <= b;
		@(posedge clk_i);
		send <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rxv === 1'b1 && n < 20);
	endtask : rx_send

	task automatic wait_tx(input logic [7:0] n0);
		int n;
		n = 0;
		while (txn === n0 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		repeat (3) @(posedge clk_i);
	endtask : wait_tx

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		{cyc, stb, we, send, stall, rxt, lse, mse} = '0;
		adr = 6'h00;
		dw = 32'h0;
		sbyte = 8'h00;
		fail_count = 0;
		checks = 0;
		rst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(6'h04, 8'h00, "enable reset");
		rd(6'h08, 8'h01, "id reset");
		chk(irq, 1'b0, "irq reset");
		foreach (rows[i]) begin
			wb(1'b1, rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e, "row readback");
		end
		chk({lcto, mcto}, 16'ha53c, "control outputs");
		rd(6'h18, 8'h90, "modem status");
		chk({lsrd, msrd}, 2'b01, "status read pulse");
		$display("test registers done");
		// legacy priority and gating
		wb(1'b1, 6'h04, 8'h0f);
		mse <= 1'b1;
		rd(6'h08, 8'h00, "modem code");
		chk(irq, 1'b1, "irq modem");
		lse <= 1'b1;
		rx_send(8'h5e);
		rd(6'h08, 8'h06, "line wins");
		lse <= 1'b0;
		rd(6'h08, 8'h04, "rx over modem");
		rd(6'h00, 8'h5e, "holding byte");
		rd(6'h08, 8'h00, "modem again");
		wb(1'b1, 6'h04, 8'h00);
		rd(6'h08, 8'h01, "gated none");
		chk(irq, 1'b0, "irq gated");
		mse <= 1'b0;
		$display("test priority done");
		// transmit low level set and clear
		wb(1'b1, 6'h04, 8'h02);
		stall <= 1'b1;
		wb(1'b1, 6'h00, 8'h3c);
		chk({txv, txd}, {1'b1, 8'h3c}, "tx holding");
		stall <= 1'b0;
		wait_tx(8'h00);
		chk(last_tx, 8'h3c, "tx byte out");
		chk(irq, 1'b1, "irq tx low");
		stall <= 1'b1;
		wb(1'b1, 6'h00, 8'h77);
		rd(6'h08, 8'h01, "cleared by write");
		stall <= 1'b0;
		wait_tx(8'h01);
		rd(6'h08, 8'h02, "tx low code");
		rd(6'h08, 8'h01, "cleared by read");
		$display("test transmit done");
		// fifo mode, threshold four, time-out
		wb(1'b1, 6'h08, 8'h41);
		chk(fen, 1'b1, "fifo enable");
		wb(1'b1, 6'h04, 8'h01);
		for (int i = 1; i < 4; i++)
			rx_send(8'(i * 17));
		rd(6'h08, 8'hc1, "below threshold");
		rx_send(8'h44);
		rd(6'h08, 8'hc4, "at threshold");
		chk(irq, 1'b1, "irq rx");
		for (int i = 1; i < 5; i++)
			rd(6'h00, 8'(i * 17), "fifo order");
		rx_send(8'h55);
		rxt <= 1'b1;
		rd(6'h08, 8'hcc, "time-out code");
		rd(6'h00, 8'h55, "time-out byte");
		rxt <= 1'b0;
		wb(1'b1, 6'h08, 8'h47);
		chk({rxrs, txrs}, 2'b11, "soft reset pulses");
		$display("test fifo done");
		// extended mode
		wb(1'b1, 6'h20, 8'h01);
		chk(ext, 1'b1, "extended");
		wb(1'b1, 6'h04, 8'hff);
		rd(6'h04, 8'h2f, "extended enable");
		chk(irq, 1'b1, "irq extended");
		mse <= 1'b1;
		rd(6'h08, 8'h2a, "event flags");
		wb(1'b1, 6'h04, 8'h00);
		rd(6'h08, 8'h2a, "flags unmasked");
		chk(irq, 1'b0, "irq masked");
		wb(1'b1, 6'h04, 8'h20);
		chk(irq, 1'b1, "irq tx empty");
		mse <= 1'b0;
		wb(1'b1, 6'h20, 8'h00);
		rd(6'h04, 8'h00, "leave extended");
		$display("test extended done");
		end_of_test();
	end
endmodule : ub0_bank0_bench
